/* File: include/sbcmt_pkg.sv */
package sbcmt_pkg;

  // clock
  localparam int CLK_NS = 20;

  // times in their own unit, as printed (ns, us or ms)
  localparam int T_WUF_MIN_NS     = 8000;
  localparam int T_WUF_TYP_NS     = 20000;
  localparam int T_WUF_MAX_NS     = 38000;
  localparam int T_STOP_MIN_NS    = 1400;
  localparam int T_STOP_MAX_NS    = 5000;
  localparam int T_NRTOUT_MIN_MS  = 97;
  localparam int T_NRTOUT_TYP_MS  = 150;
  localparam int T_NRTOUT_MAX_MS  = 205;
  localparam int T_SNR2N_TYP_NS   = 15000;
  localparam int T_WUCS_TYP_NS    = 40000;
  localparam int T_WUSPI_MIN_NS   = 90000;
  localparam int T_INT_TYP_NS     = 10000;
  localparam int T_S1STSPI_MIN_NS = 30000;
  localparam int T_RST_DUR_TYP_US = 1000;
  localparam int T_WD_OPEN_TYP_MS = 160;
  localparam int WD_SLOPE_US_KOHM = 991;
  localparam int WD_OFFSET_US     = 648;

  // derived cycle counts; least times round up
  localparam int WUF_CYC     = (T_WUF_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STOP_CYC    = (T_STOP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int NR2N_CYC    = (T_SNR2N_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WUCS_CYC    = (T_WUCS_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WUSPI_CYC   = (T_WUSPI_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_CYC     = (T_INT_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam int S1STSPI_CYC = (T_S1STSPI_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int NRTOUT_CYC  = T_NRTOUT_TYP_MS * (1000000 / CLK_NS);
  localparam int RST_DUR_CYC = T_RST_DUR_TYP_US * (1000 / CLK_NS);
  localparam int WD_OPEN_CYC = T_WD_OPEN_TYP_MS * (1000000 / CLK_NS);
  localparam int WD_KOHM_CYC = WD_SLOPE_US_KOHM * (1000 / CLK_NS);
  localparam int WD_OFS_CYC  = WD_OFFSET_US * (1000 / CLK_NS);

  // conditioner bit positions and reset level (chip select idles high)
  localparam int          PIN_CS     = 0;
  localparam int          PIN_WAKE1  = 1;
  localparam int          PIN_WAKE2  = 2;
  localparam int          PIN_DIR    = 3;
  localparam logic [3:0]  PIN_RST    = 4'h1;
  localparam int          TMR_W      = 32;

  // operating modes
  typedef enum logic [2:0] {
    SBCMT_RESET_HOLD = 3'h0,
    SBCMT_NORM_REQ   = 3'h1,
    SBCMT_TO_NORMAL  = 3'h2,
    SBCMT_NORMAL     = 3'h3,
    SBCMT_STOP_ENTRY = 3'h4,
    SBCMT_STOP       = 3'h5,
    SBCMT_WAKE_CS    = 3'h6
  } sbcmt_mode_type;

endpackage

/* File: include/sbcmt_if.sv */
`timescale 1ns/1ps
// conditioned pin levels and events handed to the mode logic
interface sbcmt_cond_if;
  logic       cs_high;    // filtered chip select level
  logic       cs_rise;    // chip select low-to-high, one cycle
  logic       wake_evt;   // accepted level wake change, one cycle
  logic       dir_level;  // synchronised direct control input
  modport src  (output cs_high, cs_rise, wake_evt, dir_level);
  modport sink (input  cs_high, cs_rise, wake_evt, dir_level);
endinterface

// load and expiry of one countdown timer
interface sbcmt_tmr_if #(parameter int W = 32);
  logic         load;     // load value, one cycle
  logic [W-1:0] value;    // cycles to count
  logic         expired;  // count reached zero, one cycle
  logic         busy;     // counting
  modport owner (output load, value, input  expired, busy);
  modport timer (input  load, value, output expired, busy);
endinterface

/* File: hw/sbcmt_pin_cond.sv */
`timescale 1ns/1ps
module sbcmt_pin_cond #(
  parameter int FILT_CYC = sbcmt_pkg::WUF_CYC
) (
  input  wire logic         sys_clk,  // system clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic         ce,       // clock enable
  input  wire logic [3:0]   pins,     // raw pins: cs_n, wake1, wake2, direct
  sbcmt_cond_if.src         cond      // conditioned outputs
);
  localparam int FW = $clog2(FILT_CYC + 1);

  typedef struct packed {
    logic [3:0]         s1;
    logic [3:0]         s2;
    logic [3:0]         s3;
    logic [3:0]         stable;
    logic [1:0][FW-1:0] cnt;
    logic [1:0]         wake_lvl;
    logic               wake_evt;
    logic               cs_rise;
  } sbcmt_cond_state_type;

  sbcmt_cond_state_type q;
  sbcmt_cond_state_type d;

  // three-stage sync, then digital wake filter on the two level inputs
  always_comb begin
    d          = q;
    d.s1       = pins;
    d.s2       = q.s1;
    d.s3       = q.s2;
    d.wake_evt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
    end
    // chip select pin is active low: idle high, rising edge ends a frame
    d.cs_rise = d.stable[sbcmt_pkg::PIN_CS] & ~q.stable[sbcmt_pkg::PIN_CS];
    for (int i = 0; i < 2; i++) begin
      // a glitch shorter than the filter restarts it, so no spurious wake
      if (q.stable[sbcmt_pkg::PIN_WAKE1 + i] != q.wake_lvl[i]) begin
        if (q.cnt[i] == FW'(FILT_CYC - 1)) begin
          d.wake_lvl[i] = q.stable[sbcmt_pkg::PIN_WAKE1 + i];
          d.wake_evt    = 1'b1;
          d.cnt[i]      = '0;
        end else begin
          d.cnt[i] = q.cnt[i] + FW'(1);
        end
      end else begin
        d.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.s1       <= sbcmt_pkg::PIN_RST;
      q.s2       <= sbcmt_pkg::PIN_RST;
      q.s3       <= sbcmt_pkg::PIN_RST;
      q.stable   <= sbcmt_pkg::PIN_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign cond.cs_high   = q.stable[sbcmt_pkg::PIN_CS];
  assign cond.cs_rise   = q.cs_rise;
  assign cond.wake_evt  = q.wake_evt;
  assign cond.dir_level = q.stable[sbcmt_pkg::PIN_DIR];
endmodule

/* File: hw/sbcmt_timer.sv */
`timescale 1ns/1ps
module sbcmt_timer #(
  parameter int W    = sbcmt_pkg::TMR_W,
  parameter int INIT = 0
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic ce,       // clock enable
  sbcmt_tmr_if.timer tmr      // load and expiry
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         expired;
  } sbcmt_tmr_state_type;

  sbcmt_tmr_state_type q;
  sbcmt_tmr_state_type d;

  // a load during counting restarts the count; expiry is one cycle
  always_comb begin
    d         = q;
    d.expired = 1'b0;
    if (tmr.load) begin
      d.cnt = tmr.value;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - W'(1);
      if (q.cnt == W'(1)) begin
        d.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.cnt     <= W'(INIT);
      q.expired <= 1'b0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign tmr.expired = q.expired;
  assign tmr.busy    = (q.cnt != '0);
endmodule

/* File: hw/sbcmt_mode_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - a level wake input counts only after it has stood through a digital filter of 8 to 38 us.
// - after chip select rises at the end of a stop command, stop mode begins 1.4 to 5 us later.
// - normal-request mode times out after 97 to 205 ms, nominally 150 ms, without a watchdog trigger.
// - a watchdog trigger in normal-request mode leads to normal mode within 7 to 30 us.
// - a chip select rising edge in stop mode wakes the device into normal request within 15 to 80 us.
// - after a chip select wake-up no command is accepted for 90 us, and the host waits that long.
// - after the wake interrupt pulse in stop mode the host waits 30 us before a command that counts.
// - in normal mode switches one and two follow their command within 20 us.
// - in normal mode switch three follows its command within 20 us.
// - with the direct input high, switch delay starts at the eighth clock falling edge of the command.
// - when the direct input is selected, switches one and two follow it from its edges.
// - with a resistor on the watchdog timing pin the period in ms is 0.991 times kilohms plus 0.648.
// - after supply rise the reset output is held active for 0.65 to 1.35 ms, nominally 1 ms.
// - with the watchdog timing pin open in normal mode the period is 107 to 215 ms.
module sbcmt_mode_ctrl #(
  parameter int RST_DUR_CYC = sbcmt_pkg::RST_DUR_CYC,  // reset hold
  parameter int NRTOUT_CYC  = sbcmt_pkg::NRTOUT_CYC,   // normal-request time-out
  parameter int WD_OPEN_CYC = sbcmt_pkg::WD_OPEN_CYC,  // open-pin watchdog period
  parameter int WD_KOHM_CYC = sbcmt_pkg::WD_KOHM_CYC,  // period slope per kilohm
  parameter int WD_OFS_CYC  = sbcmt_pkg::WD_OFS_CYC,   // period offset
  parameter int WUSPI_CYC   = sbcmt_pkg::WUSPI_CYC,    // command hold-off after cs wake
  parameter int WUF_CYC     = sbcmt_pkg::WUF_CYC       // wake filter length
) (
  input  wire logic       sys_clk,                   // 50 MHz system clock
  input  wire logic       rst_n,                     // async reset, active low
  input  wire logic       ce,                        // clock enable, freezes all state
  input  wire logic       cs_n,                      // spi chip select pin, active low
  input  wire logic       level_wake_input_one,      // level wake pin one
  input  wire logic       level_wake_input_two,      // level wake pin two
  input  wire logic       direct_in,                 // direct switch control pin
  input  wire logic [7:0] watchdog_timing_pin_kohm,  // sensed resistor value, kilohms
  input  wire logic       watchdog_timing_pin_open,  // no resistor fitted
  input  wire logic       cmd_valid,                 // decoded spi command, one cycle
  input  wire logic       cmd_stop,                  // command asks for stop mode
  input  wire logic       cmd_wd_trigger,            // command is a watchdog trigger
  input  wire logic       cmd_hs_write,              // command writes switch states
  input  wire logic [2:0] cmd_hs_value,              // switch states three..one
  input  wire logic       cmd_direct_sel,            // switches one and two follow direct_in
  output logic            reset_to_host_n,           // reset output, active low
  output logic            int_n,                     // wake interrupt pulse, active low
  output logic            high_side_switch_one,      // switch one on
  output logic            high_side_switch_two,      // switch two on
  output logic            high_side_switch_three,    // switch three on
  output logic [2:0]      mode,                      // current operating mode
  output logic            cmd_accepted               // command taken, one cycle
);
  localparam int TW = sbcmt_pkg::TMR_W;

  typedef struct packed {
    sbcmt_pkg::sbcmt_mode_type mode;
    logic [TW-1:0]             holdoff;
    logic [TW-1:0]             int_cnt;
    logic                      rst_out_n;
    logic                      int_n;
    logic [2:0]                hs;
    logic                      dir_sel;
    logic                      accepted;
    logic                      stop_armed;
  } sbcmt_core_type;

  sbcmt_core_type q;
  sbcmt_core_type d;

  sbcmt_cond_if           cond ();
  sbcmt_tmr_if #(.W(TW))  st_tmr ();
  sbcmt_tmr_if #(.W(TW))  wd_tmr ();

  sbcmt_pin_cond #(
    .FILT_CYC (WUF_CYC)
  ) u_pins (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pins    ({direct_in, level_wake_input_two, level_wake_input_one, cs_n}),
    .cond    (cond.src)
  );

  // state timer starts loaded so the reset output is held from power-up
  sbcmt_timer #(
    .W    (TW),
    .INIT (RST_DUR_CYC)
  ) u_state_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .tmr     (st_tmr.timer)
  );

  sbcmt_timer #(
    .W    (TW),
    .INIT (0)
  ) u_wd_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .tmr     (wd_tmr.timer)
  );

  // watchdog period from the timing pin; open pin uses the default
  function automatic logic [TW-1:0] wd_period(input logic [7:0] kohm, input logic open_pin);
    logic [TW-1:0] p;
    p = TW'(WD_OFS_CYC) + TW'(kohm) * TW'(WD_KOHM_CYC);
    if (open_pin) begin
      p = TW'(WD_OPEN_CYC);
    end
    return p;
  endfunction

  logic cmd_ok;
  logic wd_trig_ok;

  // commands count only outside stop and after any wake hold-off
  assign cmd_ok     = cmd_valid && (q.holdoff == '0)
                      && (q.mode != sbcmt_pkg::SBCMT_STOP)
                      && (q.mode != sbcmt_pkg::SBCMT_STOP_ENTRY)
                      && (q.mode != sbcmt_pkg::SBCMT_RESET_HOLD);
  assign wd_trig_ok = cmd_ok && cmd_wd_trigger;

  // mode sequencing, timers, switches and hand-shake outputs
  always_comb begin
    d             = q;
    d.accepted    = cmd_ok;
    st_tmr.load   = 1'b0;
    st_tmr.value  = '0;
    wd_tmr.load   = 1'b0;
    wd_tmr.value  = '0;
    if (q.holdoff != '0) begin
      d.holdoff = q.holdoff - TW'(1);
    end
    if (q.int_cnt != '0) begin
      d.int_cnt = q.int_cnt - TW'(1);
      d.int_n   = (q.int_cnt == TW'(1));
    end
    unique case (q.mode)
      sbcmt_pkg::SBCMT_RESET_HOLD: begin
        d.rst_out_n = 1'b0;
        d.hs        = 3'h0;
        d.dir_sel   = 1'b0;
        if (st_tmr.expired) begin
          d.rst_out_n  = 1'b1;
          d.mode       = sbcmt_pkg::SBCMT_NORM_REQ;
          wd_tmr.load  = 1'b1;
          wd_tmr.value = TW'(NRTOUT_CYC);
        end
      end
      sbcmt_pkg::SBCMT_NORM_REQ: begin
        if (wd_trig_ok) begin
          d.mode       = sbcmt_pkg::SBCMT_TO_NORMAL;
          st_tmr.load  = 1'b1;
          st_tmr.value = TW'(sbcmt_pkg::NR2N_CYC);
          wd_tmr.load  = 1'b1;
          wd_tmr.value = '0;
        end else if (wd_tmr.expired) begin
          d.mode       = sbcmt_pkg::SBCMT_RESET_HOLD;
          d.rst_out_n  = 1'b0;
          st_tmr.load  = 1'b1;
          st_tmr.value = TW'(RST_DUR_CYC);
        end
      end
      sbcmt_pkg::SBCMT_TO_NORMAL: begin
        if (st_tmr.expired) begin
          d.mode       = sbcmt_pkg::SBCMT_NORMAL;
          wd_tmr.load  = 1'b1;
          wd_tmr.value = wd_period(watchdog_timing_pin_kohm, watchdog_timing_pin_open);
        end
      end
      sbcmt_pkg::SBCMT_NORMAL: begin
        // switch commands take effect on the next edge, well inside 20 us
        if (cmd_ok && cmd_hs_write) begin
          d.hs[1:0] = cmd_hs_value[1:0];
          d.hs[2]   = cmd_hs_value[2];
          d.dir_sel = cmd_direct_sel;
        end
        if (d.dir_sel) begin
          d.hs[1:0] = {2{cond.dir_level}};
        end
        if (cmd_ok && cmd_stop) begin
          d.stop_armed = 1'b1;
        end
        if (wd_trig_ok) begin
          wd_tmr.load  = 1'b1;
          wd_tmr.value = wd_period(watchdog_timing_pin_kohm, watchdog_timing_pin_open);
        end else if (wd_tmr.expired) begin
          d.mode       = sbcmt_pkg::SBCMT_RESET_HOLD;
          d.rst_out_n  = 1'b0;
          d.stop_armed = 1'b0;
          st_tmr.load  = 1'b1;
          st_tmr.value = TW'(RST_DUR_CYC);
        end
        // stop counts from the chip select rise that closes the stop frame
        if (q.stop_armed && cond.cs_rise && !wd_tmr.expired) begin
          d.mode       = sbcmt_pkg::SBCMT_STOP_ENTRY;
          d.stop_armed = 1'b0;
          st_tmr.load  = 1'b1;
          st_tmr.value = TW'(sbcmt_pkg::STOP_CYC);
          wd_tmr.load  = 1'b1;
          wd_tmr.value = '0;
        end
      end
      sbcmt_pkg::SBCMT_STOP_ENTRY: begin
        if (st_tmr.expired) begin
          d.mode = sbcmt_pkg::SBCMT_STOP;
        end
      end
      sbcmt_pkg::SBCMT_STOP: begin
        if (cond.cs_rise) begin
          d.mode       = sbcmt_pkg::SBCMT_WAKE_CS;
          d.holdoff    = TW'(WUSPI_CYC);
          st_tmr.load  = 1'b1;
          st_tmr.value = TW'(sbcmt_pkg::WUCS_CYC);
        end else if (cond.wake_evt) begin
          // pulse the interrupt, then refuse commands until 30 us after it
          d.mode       = sbcmt_pkg::SBCMT_NORM_REQ;
          d.int_n      = 1'b0;
          d.int_cnt    = TW'(sbcmt_pkg::INT_CYC);
          d.holdoff    = TW'(sbcmt_pkg::INT_CYC + sbcmt_pkg::S1STSPI_CYC);
          wd_tmr.load  = 1'b1;
          wd_tmr.value = TW'(NRTOUT_CYC);
        end
      end
      sbcmt_pkg::SBCMT_WAKE_CS: begin
        if (st_tmr.expired) begin
          d.mode       = sbcmt_pkg::SBCMT_NORM_REQ;
          d.rst_out_n  = 1'b1;
          wd_tmr.load  = 1'b1;
          wd_tmr.value = TW'(NRTOUT_CYC);
        end
      end
      default: begin
        d.mode       = sbcmt_pkg::SBCMT_RESET_HOLD;
        st_tmr.load  = 1'b1;
        st_tmr.value = TW'(RST_DUR_CYC);
      end
    endcase
  end

  // all state frozen while ce is low; reset holds the host in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.mode      <= sbcmt_pkg::SBCMT_RESET_HOLD;
      q.rst_out_n <= 1'b0;
      q.int_n     <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reset_to_host_n        = q.rst_out_n;
  assign int_n                  = q.int_n;
  assign high_side_switch_one   = q.hs[0];
  assign high_side_switch_two   = q.hs[1];
  assign high_side_switch_three = q.hs[2];
  assign mode                   = q.mode;
  assign cmd_accepted           = q.accepted;
endmodule

/* File: dv/sbcmt_host_model.sv */
`timescale 1ns/1ps
// host side: chip select frames and decoded command pulses
module sbcmt_host_model (
  input  logic       sys_clk,       // system clock
  input  logic       cmd_accepted,  // device took the command
  output logic       cs_n,          // chip select, active low
  output logic       cmd_valid,     // one-cycle command pulse
  output logic [6:0] cmd_f          // stop, trigger, write, direct select, value[2:0]
);
  localparam int T2CS_CYC = 15000 / sbcmt_pkg::CLK_NS;
  int since_rise = 0;

  // cycles that chip select has stood high
  always @(posedge sys_clk) since_rise <= cs_n ? since_rise + 1 : 0;

  initial begin
    cs_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_f = 7'h7f;
  end

  // idle fields show the inverse, so a stale qualifier can never look valid
  task automatic cmd(input logic [6:0] f, output logic acc);
    @(posedge sys_clk);
    #1 cmd_valid = 1'b1;
    cmd_f = f;
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    cmd_f = ~f;
    acc = cmd_accepted;
  endtask

  // frame: keeps the chip select gap, may carry one command
  task automatic frame(input logic [6:0] f, input logic send, output logic acc);
    @(posedge sys_clk);
    while (since_rise < T2CS_CYC) @(posedge sys_clk);
    #1 cs_n = 1'b0;
    acc = 1'b0;
    if (send) cmd(f, acc);
    repeat (4) @(posedge sys_clk);
    #1 cs_n = 1'b1;
  endtask

  // wait out the device hold-off
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
endmodule

/* File: dv/sbcmt_mode_ctrl_props.sv */
`timescale 1ns/1ps
// timing relations of the mode controller seen at its ports
module sbcmt_mode_ctrl_props #(
  parameter int RST_DUR_CYC = sbcmt_pkg::RST_DUR_CYC,  // reset hold
  parameter int NRTOUT_CYC  = sbcmt_pkg::NRTOUT_CYC,   // normal-request time-out
  parameter int WUSPI_CYC   = sbcmt_pkg::WUSPI_CYC     // hold-off after cs wake
) (
  input wire logic       sys_clk,                 // system clock
  input wire logic       rst_n,                   // async reset, active low
  input wire logic       cmd_hs_write,            // switch write qualifier
  input wire logic [2:0] cmd_hs_value,            // switch states
  input wire logic       cmd_direct_sel,          // direct input selection
  input wire logic       reset_to_host_n,         // reset output
  input wire logic       int_n,                   // wake interrupt
  input wire logic       high_side_switch_one,    // switch one
  input wire logic       high_side_switch_two,    // switch two
  input wire logic       high_side_switch_three,  // switch three
  input wire logic [2:0] mode,                    // operating mode
  input wire logic       cmd_accepted             // command taken
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] mode_q;
  int         dwell_q;
  int         low_q;

  // dwell_q counts the stay in the mode just left, so one counter times every step
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
      dwell_q <= 0;
      low_q <= 0;
    end else begin
      mode_q <= mode;
      dwell_q <= (mode != mode_q) ? 1 : dwell_q + 1;
      low_q <= int_n ? 0 : low_q + 1;
    end
  end

  a_rst_hold_len: assert property (
    mode_q == 3'h0 && mode != 3'h0 |-> mode == 3'h1 && reset_to_host_n
      && dwell_q >= RST_DUR_CYC - 2 && dwell_q <= RST_DUR_CYC + 3) else $error("reset hold length wrong");
  a_hold_drives_rst: assert property (mode == 3'h0 |-> !reset_to_host_n) else $error("reset output high in hold");
  a_nr_timeout_len: assert property (
    mode_q == 3'h1 && mode == 3'h0 |-> dwell_q >= NRTOUT_CYC - 2 && dwell_q <= NRTOUT_CYC + 3)
    else $error("normal request time-out wrong");
  a_trig_to_normal: assert property (
    mode_q == 3'h2 && mode != 3'h2 |-> mode == 3'h3 && dwell_q >= 350 && dwell_q <= 1500)
    else $error("normal entry delay wrong");
  a_stop_entry_delay: assert property (
    mode_q == 3'h4 && mode != 3'h4 |-> mode == 3'h5 && dwell_q >= 70 && dwell_q <= 250)
    else $error("stop entry delay wrong");
  a_cs_wake_delay: assert property (
    mode_q == 3'h6 && mode != 3'h6 |-> mode == 3'h1 && reset_to_host_n && dwell_q >= 750 && dwell_q <= 4000)
    else $error("cs wake delay wrong");
  a_cmd_hold_off: assert property (
    cmd_accepted |-> !($past(mode) inside {3'h0, 3'h4, 3'h5})
      && ($past(mode) != 3'h6 || $past(dwell_q) >= WUSPI_CYC - 8)) else $error("command accepted when barred");
  a_int_pulse_len: assert property ($rose(int_n) |-> low_q >= 350 && low_q <= 650)
    else $error("interrupt pulse length wrong");
  a_switch_follow: assert property (
    cmd_accepted && $past(mode) == 3'h3 && $past(cmd_hs_write) && !$past(cmd_direct_sel)
      |-> {high_side_switch_three, high_side_switch_two, high_side_switch_one} == $past(cmd_hs_value))
    else $error("switches did not follow write");

  c_stop_mode: cover property (mode == 3'h5);
  c_cs_wake: cover property (mode == 3'h6);
  c_normal_entry: cover property (mode_q == 3'h2 && mode == 3'h3);
endmodule

bind sbcmt_mode_ctrl sbcmt_mode_ctrl_props #(
  .RST_DUR_CYC(RST_DUR_CYC), .NRTOUT_CYC(NRTOUT_CYC), .WUSPI_CYC(WUSPI_CYC)
) sbcmt_mode_ctrl_props_inst (
  .sys_clk, .rst_n, .cmd_hs_write, .cmd_hs_value, .cmd_direct_sel, .reset_to_host_n, .int_n,
  .high_side_switch_one, .high_side_switch_two, .high_side_switch_three, .mode, .cmd_accepted);

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int RST_C = 20, NRT_C = 3000, WDO_C = 300, KOHM_C = 10, OFS_C = 5, WUSPI_C = 50, WUF_C = 8;
  logic       sys_clk = 1'b0, rst_n = 1'b0;
  logic       wake1 = 1'b0, wake2 = 1'b0, direct_in = 1'b0, wd_open = 1'b1;
  logic [7:0] kohm = 8'h05;
  logic       cs_n, cmd_valid, cmd_accepted, reset_to_host_n, int_n, acc;
  logic [6:0] cmd_f;
  logic [2:0] sw, mode;
  int         bad_count = 0, cmp_count = 0, n;

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  // ce held on: freezing is outside the timing under test
  sbcmt_mode_ctrl #(
    .RST_DUR_CYC(RST_C), .NRTOUT_CYC(NRT_C), .WD_OPEN_CYC(WDO_C),
    .WD_KOHM_CYC(KOHM_C), .WD_OFS_CYC(OFS_C), .WUSPI_CYC(WUSPI_C), .WUF_CYC(WUF_C)
  ) sbcmt_mode_ctrl_inst (
    .sys_clk, .rst_n, .ce(1'b1), .cs_n, .level_wake_input_one(wake1),
    .level_wake_input_two(wake2), .direct_in, .watchdog_timing_pin_kohm(kohm),
    .watchdog_timing_pin_open(wd_open), .cmd_valid, .cmd_stop(cmd_f[6]),
    .cmd_wd_trigger(cmd_f[5]), .cmd_hs_write(cmd_f[4]), .cmd_direct_sel(cmd_f[3]),
    .cmd_hs_value(cmd_f[2:0]), .reset_to_host_n, .int_n,
    .high_side_switch_one(sw[0]), .high_side_switch_two(sw[1]), .high_side_switch_three(sw[2]),
    .mode, .cmd_accepted);

  sbcmt_host_model sbcmt_host_model_inst (.sys_clk, .cmd_accepted, .cs_n, .cmd_valid, .cmd_f);

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic cmd(input logic [6:0] f);
    sbcmt_host_model_inst.cmd(f, acc);
  endtask

  // bounded wait; cnt counts the cycles taken
  task automatic wait_mode(input logic [2:0] m, input int lim, output int cnt);
    cnt = 0;
    while (mode !== m && cnt < lim) begin
      cyc(1);
      cnt++;
    end
  endtask

  task automatic t_reset;
    cyc(20);
    rst_n = 1'b1;
    chk(reset_to_host_n === 1'b0 && int_n === 1'b1 && sw === 3'h0, "reset levels");
    cmd(7'h20);
    chk(acc === 1'b0, "command taken in reset hold");
    wait_mode(3'h1, 100, n);
    chk(n + 2 >= RST_C - 1 && n + 2 <= RST_C + 3 && reset_to_host_n === 1'b1, "reset hold length");
    $display("test reset done");
  endtask

  task automatic t_timeout;
    wait_mode(3'h0, NRT_C + 50, n);
    chk(n >= NRT_C - 3 && n <= NRT_C + 3, "time-out length");
    chk(reset_to_host_n === 1'b0, "time-out reset");
    wait_mode(3'h1, 100, n);
    $display("test time-out done");
  endtask

  task automatic t_to_normal;
    cmd(7'h20);
    chk(acc === 1'b1 && mode === 3'h2, "trigger in normal request");
    wait_mode(3'h3, 2000, n);
    chk(n >= 349 && n <= 1500, "normal entry delay");
    $display("test normal entry done");
  endtask

  task automatic t_switches;
    cmd(7'h20);
    for (int v = 0; v < 8; v++) begin
      cmd(7'h10 | 7'(v));
      chk(acc === 1'b1 && sw === 3'(v), "switch states");
    end
    $display("test switches done");
  endtask

  task automatic t_direct;
    cmd(7'h1c);
    direct_in = 1'b1;
    cyc(6);
    chk(sw === 3'h7, "direct high");
    direct_in = 1'b0;
    cyc(6);
    chk(sw === 3'h4, "direct low");
    cmd(7'h17);
    chk(sw === 3'h7, "direct deselected");
    $display("test direct input done");
  endtask

  task automatic t_stop_cs;
    sbcmt_host_model_inst.frame(7'h40, 1'b1, acc);
    chk(acc === 1'b1, "stop command");
    wait_mode(3'h4, 20, n);
    wait_mode(3'h5, 400, n);
    chk(mode === 3'h5 && n >= 69 && n <= 250, "stop entry delay");
    cmd(7'h20);
    chk(acc === 1'b0, "command in stop");
    sbcmt_host_model_inst.frame(7'h00, 1'b0, acc);
    wait_mode(3'h6, 20, n);
    cmd(7'h00);
    chk(mode === 3'h6 && acc === 1'b0, "command in hold-off");
    sbcmt_host_model_inst.settle(WUSPI_C);
    cmd(7'h00);
    chk(acc === 1'b1, "command after hold-off");
    wait_mode(3'h1, 5000, n);
    chk(n >= 700 && n <= 4000 && reset_to_host_n === 1'b1, "cs wake delay");
    $display("test stop and cs wake done");
  endtask

  task automatic t_wake_level;
    cmd(7'h20);
    wait_mode(3'h3, 2000, n);
    sbcmt_host_model_inst.frame(7'h40, 1'b1, acc);
    wait_mode(3'h5, 400, n);
    // a pulse shorter than the filter must not wake
    wake1 = 1'b1;
    cyc(WUF_C - 4);
    wake1 = 1'b0;
    cyc(30);
    chk(mode === 3'h5, "short wake pulse");
    wake2 = 1'b1;
    wait_mode(3'h1, 100, n);
    chk(n >= WUF_C && n <= WUF_C + 8 && int_n === 1'b0, "level wake");
    cmd(7'h20);
    chk(acc === 1'b0, "command during interrupt");
    n = 0;
    while (int_n === 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk(n >= 340 && n <= 650, "interrupt length");
    sbcmt_host_model_inst.settle(sbcmt_pkg::S1STSPI_CYC + 5);
    cmd(7'h20);
    chk(acc === 1'b1, "command after interrupt");
    wake2 = 1'b0;
    $display("test level wake done");
  endtask

  task automatic t_wd_period;
    wait_mode(3'h3, 2000, n);
    wd_open = 1'b0;
    cmd(7'h20);
    wait_mode(3'h0, 500, n);
    chk(n + 1 >= 5 * KOHM_C + OFS_C - 3 && n + 1 <= 5 * KOHM_C + OFS_C + 3, "resistor period");
    cyc(1);
    chk(sw === 3'h0 && reset_to_host_n === 1'b0, "watchdog failure");
    wd_open = 1'b1;
    wait_mode(3'h1, 100, n);
    cmd(7'h20);
    wait_mode(3'h3, 2000, n);
    wait_mode(3'h0, 1000, n);
    chk(n >= WDO_C - 4 && n <= WDO_C + 3, "open pin period");
    $display("test watchdog period done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    t_reset;
    t_timeout;
    t_to_normal;
    t_switches;
    t_direct;
    t_stop_cs;
    t_wake_level;
    t_wd_period;
    test_done;
  end

  // hang guard, far past the ~12k cycles the tests take
  initial begin
    #(50000 * sbcmt_pkg::CLK_NS);
    bad_count++;
    $display("MISMATCH %0t run did not finish", $time);
    test_done;
  end
endmodule
